// ---- pkg/srf_cfg.svh ----
// Offsets, field positions, reset values and counts of the SPI response framing block
// Operation
// - Non read-only commands answer one frame later
// - First Normal frame reports prior mode, register
// - Restart after failure reports limp-home register
// - Restart requested reports chip configuration register
// - Automatic first response never clears flags
// - One mode-select code means read only
// - Read only clears selected register's event flags
// - Read only writes nothing, keeps mode
// - Read only still services the watchdog
// - Read only answers within the same frame
// - Other commands answer in the next frame
// - Restart reasons clear on read, leaving Sleep/Fail-Safe
// - Limp-home off clears failure cause bits
`ifndef SRF_CFG_SVH
`define SRF_CFG_SVH
// Register byte addresses
`define SRF_A_MODE   8'h00
`define SRF_A_STAT   8'h04
`define SRF_A_MASK   8'h08
`define SRF_A_WAKE   8'h0c
`define SRF_A_LH     8'h10
`define SRF_A_LAST   8'h14
// Config-select codes
`define SRF_CS_CFG   3'h0
`define SRF_CS_WAKE  3'h1
`define SRF_CS_LH    3'h7
// Frame layout and counts
`define SRF_FRAME_BITS 5'h10
`define SRF_HDR_BITS   5'h06
`define SRF_RM_MASK    10'h003
`define SRF_LH_LO      2
`define SRF_LH_HI      4
`define SRF_LH_ON_BIT  0
`define SRF_REG_RST    10'h000
// Status bits
`define SRF_ST_FRAME 0
`define SRF_ST_WDOG  1
`define SRF_ST_MREQ  2
`define SRF_ST_ERR   3
`define SRF_RESP_OK  2'h0
`define SRF_RESP_ERR 2'h2
`endif

// ---- pkg/srf_pkg.sv ----
// Types of the SPI response framing block
package srf_pkg;
  typedef enum logic [2:0] {
    SRF_NORMAL    = 3'h0,
    SRF_SLEEP     = 3'h1,
    SRF_RESTART   = 3'h2,
    SRF_FAILSAFE  = 3'h3,
    SRF_INIT      = 3'h4,
    SRF_READ_ONLY = 3'h7
  } srf_mode_t;
  typedef struct packed {
    logic [9:0] data;
    logic [2:0] cfg_sel;
    logic [2:0] mode_select_bits;
  } srf_frame_t;
  typedef enum logic [0:0] {
    SRF_IDLE  = 1'b0,
    SRF_SHIFT = 1'b1
  } srf_fsm_t;
endpackage : srf_pkg

// ---- hw/srf_core.sv ----
// SPI response framing core with AXI4-Lite register access
`timescale 1ns/1ns
`include "srf_cfg.svh"
module srf_core (
  input  wire logic        aclk,           // System clock, 25 MHz
  input  wire logic        aresetn,        // Synchronous reset, active low
  input  wire logic [7:0]  awaddr,         // Write address
  input  wire logic        awvalid,        // Write address valid
  output logic             awready,        // Write address ready
  input  wire logic [31:0] wdata,          // Write data
  input  wire logic [3:0]  wstrb,          // Write byte lanes
  input  wire logic        wvalid,         // Write data valid
  output logic             wready,         // Write data ready
  output logic [1:0]       bresp,          // Write response
  output logic             bvalid,         // Write response valid
  input  wire logic        bready,         // Write response ready
  input  wire logic [7:0]  araddr,         // Read address
  input  wire logic        arvalid,        // Read address valid
  output logic             arready,        // Read address ready
  output logic [31:0]      rdata,          // Read data
  output logic [1:0]       rresp,          // Read response
  output logic             rvalid,         // Read data valid
  input  wire logic        rready,         // Read data ready
  input  wire logic        link_sclk,      // SPI clock from master
  input  wire logic        chip_select_n,  // SPI chip select, active low
  input  wire logic        serial_in_pin,  // SPI data from master
  output logic             serial_out_pin, // SPI data to master
  output logic             serial_out_oe,  // Drive enable of serial_out_pin
  output logic             wdog_service,   // One-cycle watchdog restart pulse
  output logic             limp_home_on,   // Limp-home output state
  output logic             irq             // Level interrupt
);
  import srf_pkg::*;

  // ----------------------------------------------------------------
  // Pin synchronisers and frame view
  // ----------------------------------------------------------------
  logic [2:0]  sy0_q, sy1_q;
  logic [1:0]  prev_q;
  logic        sclk_rise, cs_idle, din;
  srf_fsm_t    fsm_q, fsm_d;
  logic [4:0]  cnt_q, cnt_d;
  logic [15:0] rxw_q, rxw_d, txw, last_q, last_d;
  srf_frame_t  rxf, rof, resp_q, resp_d;
  logic [2:0]  sel, fsel;
  logic        is_ro, ro_hit, commit, entry, mode_wr;
  logic [9:0]  rclr;
  logic [9:0]  regs_q [8];
  logic [9:0]  regs_d [8];
  logic [2:0]  mode_q, mode_d;
  logic        rfail_q, rfail_d, limp_q, limp_d, wdog_q, wdog_d;
  logic        so_q, so_d, oe_q, oe_d, irq_q, irq_d;
  logic [3:0]  stat_q, stat_d, mask_q, mask_d, set, rdclr;

  assign sclk_rise = sy1_q[0] & ~prev_q[0];
  assign cs_idle   = sy1_q[1];
  assign din       = sy1_q[2];
  assign rxf       = rxw_q;
  assign sel       = rxf.cfg_sel;
  assign is_ro     = rxf.mode_select_bits == SRF_READ_ONLY;
  assign ro_hit    = is_ro && (cnt_q >= `SRF_HDR_BITS);
  assign commit    = (fsm_q == SRF_SHIFT) && cs_idle && (cnt_q == `SRF_FRAME_BITS);
  // Live limp-home cause bits survive a read; only restart reasons clear
  assign rclr      = !is_ro ? 10'h000 : (sel == `SRF_CS_WAKE) ? 10'h3ff :
                     (sel == `SRF_CS_LH) ? `SRF_RM_MASK : 10'h000;
  assign rof       = '{data: regs_q[sel], cfg_sel: sel, mode_select_bits: rxf.mode_select_bits};
  assign txw       = ro_hit ? rof : resp_q;

  // ----------------------------------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------------------------------
  logic        aw_ok_q, aw_ok_d, w_ok_q, w_ok_d, bv_q, bv_d, rv_q, rv_d;
  logic [7:0]  awa_q, awa_d;
  logic [31:0] wd_q, wd_d, wv, rd_q, rd_d;
  logic [3:0]  ws_q, ws_d;
  logic [1:0]  br_q, br_d, rr_q, rr_d;
  logic        wr_go, rd_go;

  assign awready = !aw_ok_q && !bv_q;
  assign wready  = !w_ok_q && !bv_q;
  assign arready = !rv_q;
  assign bvalid  = bv_q;
  assign bresp   = br_q;
  assign rvalid  = rv_q;
  assign rdata   = rd_q;
  assign rresp   = rr_q;
  assign wr_go   = aw_ok_q && w_ok_q;
  assign rd_go   = arvalid && arready;
  assign wv      = wd_q & {{8{ws_q[3]}}, {8{ws_q[2]}}, {8{ws_q[1]}}, {8{ws_q[0]}}};
  assign mode_wr = wr_go && (awa_q == `SRF_A_MODE) && ws_q[0];

  always_comb
  begin
    aw_ok_d = aw_ok_q;
    w_ok_d  = w_ok_q;
    awa_d   = awa_q;
    wd_d    = wd_q;
    ws_d    = ws_q;
    bv_d    = bv_q && !bready;
    br_d    = br_q;
    rv_d    = rv_q && !rready;
    rd_d    = rd_q;
    rr_d    = rr_q;
    rdclr   = 4'h0;
    if (awvalid && awready)
    begin
      aw_ok_d = 1'b1;
      awa_d   = awaddr;
    end
    if (wvalid && wready)
    begin
      w_ok_d = 1'b1;
      wd_d   = wdata;
      ws_d   = wstrb;
    end
    if (wr_go)
    begin
      aw_ok_d = 1'b0;
      w_ok_d  = 1'b0;
      bv_d    = 1'b1;
      br_d    = (awa_q <= `SRF_A_LH && awa_q[1:0] == 2'h0 && awa_q != `SRF_A_STAT) ?
                `SRF_RESP_OK : `SRF_RESP_ERR;
    end
    if (rd_go)
    begin
      rv_d = 1'b1;
      rr_d = `SRF_RESP_OK;
      case (araddr)
        `SRF_A_MODE: rd_d = {27'h000_0000, limp_q, rfail_q, mode_q};
        `SRF_A_STAT:
        begin
          rd_d  = {28'h000_0000, stat_q};
          rdclr = 4'hf;
        end
        `SRF_A_MASK: rd_d = {28'h000_0000, mask_q};
        `SRF_A_WAKE: rd_d = {22'h00_0000, regs_q[`SRF_CS_WAKE]};
        `SRF_A_LH:   rd_d = {22'h00_0000, regs_q[`SRF_CS_LH]};
        `SRF_A_LAST: rd_d = {16'h0000, last_q};
        default:
        begin
          rd_d = 32'h0000_0000;
          rr_d = `SRF_RESP_ERR;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Frame engine, chip mode and flag registers
  // ----------------------------------------------------------------
  always_comb
  begin
    fsm_d  = fsm_q;
    cnt_d  = cnt_q;
    rxw_d  = rxw_q;
    resp_d = resp_q;
    regs_d = regs_q;
    mode_d = mode_q;
    rfail_d = rfail_q;
    limp_d = limp_q;
    mask_d = mask_q;
    last_d = last_q;
    wdog_d = 1'b0;
    set    = 4'h0;
    fsel   = `SRF_CS_CFG;
    entry  = 1'b0;
    so_d   = cnt_q[4] ? 1'b0 : txw[cnt_q[3:0]];
    unique case (fsm_q)
      SRF_IDLE:
        if (!cs_idle)
          fsm_d = SRF_SHIFT;
      SRF_SHIFT:
        if (cs_idle)
        begin
          fsm_d = SRF_IDLE;
          cnt_d = 5'h00;
          if (cnt_q == `SRF_FRAME_BITS)
          begin
            wdog_d = 1'b1;
            set[`SRF_ST_FRAME] = 1'b1;
            set[`SRF_ST_WDOG]  = 1'b1;
            // Response for the next frame is latched at chip select release
            resp_d = '{data: regs_q[sel] & ~rclr, cfg_sel: sel,
                       mode_select_bits: mode_q};
            if (is_ro)
              regs_d[sel] = regs_q[sel] & ~rclr;
            else
            begin
              last_d = rxw_q;
              set[`SRF_ST_MREQ] = 1'b1;
              if (sel == `SRF_CS_LH)
              begin
                limp_d = rxf.data[`SRF_LH_ON_BIT];
                if (!rxf.data[`SRF_LH_ON_BIT])
                  regs_d[`SRF_CS_LH][`SRF_LH_HI:`SRF_LH_LO] = 3'h0;
              end
              else if (sel != `SRF_CS_WAKE)
                regs_d[sel] = rxf.data;
            end
          end
          else
            set[`SRF_ST_ERR] = 1'b1;
        end
        else if (sclk_rise && !cnt_q[4])
        begin
          rxw_d[cnt_q[3:0]] = din;
          cnt_d = cnt_q + 5'h01;
        end
    endcase
    // Hardware events set after any clear in the same cycle
    if (wr_go)
      case (awa_q)
        `SRF_A_MODE:
          if (ws_q[0])
          begin
            mode_d  = wv[2:0];
            rfail_d = wv[3];
          end
        `SRF_A_MASK:
          if (ws_q[0])
            mask_d = wv[3:0];
        `SRF_A_WAKE: regs_d[`SRF_CS_WAKE] = regs_d[`SRF_CS_WAKE] | wv[9:0];
        `SRF_A_LH:
        begin
          regs_d[`SRF_CS_LH] = regs_d[`SRF_CS_LH] | wv[9:0];
          if (wv[`SRF_LH_HI:`SRF_LH_LO] != 3'h0)
            limp_d = 1'b1;
        end
        default: ;
      endcase
    if (mode_d != mode_q)
    begin
      if (mode_q == SRF_SLEEP || mode_q == SRF_FAILSAFE)
        regs_d[`SRF_CS_LH] = regs_d[`SRF_CS_LH] & ~`SRF_RM_MASK;
      if (mode_d == SRF_NORMAL)
      begin
        entry = 1'b1;
        if (mode_q == SRF_SLEEP)
          fsel = `SRF_CS_WAKE;
        else if (mode_q == SRF_FAILSAFE || (mode_q == SRF_RESTART && rfail_q))
          fsel = `SRF_CS_LH;
        // Prior contents go out; flags stay set, except the restart reasons cleared above when leaving Sleep/Fail-Safe
        resp_d = '{data: regs_q[fsel], cfg_sel: fsel, mode_select_bits: mode_q};
      end
    end
    oe_d  = fsm_d == SRF_SHIFT;
    irq_d = |((stat_q & ~rdclr | set) & mask_d);
  end

  assign stat_d = (stat_q & ~rdclr) | set;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sy0_q   <= 3'h2;
      sy1_q   <= 3'h2;
      prev_q  <= 2'h2;
      fsm_q   <= SRF_IDLE;
      cnt_q   <= 5'h00;
      rxw_q   <= 16'h0000;
      resp_q  <= '{data: `SRF_REG_RST, cfg_sel: `SRF_CS_CFG, mode_select_bits: SRF_INIT};
      regs_q  <= '{default: `SRF_REG_RST};
      mode_q  <= SRF_INIT;
      rfail_q <= 1'b0;
      limp_q  <= 1'b0;
      mask_q  <= 4'h0;
      stat_q  <= 4'h0;
      last_q  <= 16'h0000;
      wdog_q  <= 1'b0;
      so_q    <= 1'b0;
      oe_q    <= 1'b0;
      irq_q   <= 1'b0;
      aw_ok_q <= 1'b0;
      w_ok_q  <= 1'b0;
      awa_q   <= 8'h00;
      wd_q    <= 32'h0000_0000;
      ws_q    <= 4'h0;
      bv_q    <= 1'b0;
      br_q    <= `SRF_RESP_OK;
      rv_q    <= 1'b0;
      rd_q    <= 32'h0000_0000;
      rr_q    <= `SRF_RESP_OK;
    end
    else
    begin
      sy0_q   <= {serial_in_pin, chip_select_n, link_sclk};
      sy1_q   <= sy0_q;
      prev_q  <= sy1_q[1:0];
      fsm_q   <= fsm_d;
      cnt_q   <= cnt_d;
      rxw_q   <= rxw_d;
      resp_q  <= resp_d;
      regs_q  <= regs_d;
      mode_q  <= mode_d;
      rfail_q <= rfail_d;
      limp_q  <= limp_d;
      mask_q  <= mask_d;
      stat_q  <= stat_d;
      last_q  <= last_d;
      wdog_q  <= wdog_d;
      so_q    <= so_d;
      oe_q    <= oe_d;
      irq_q   <= irq_d;
      aw_ok_q <= aw_ok_d;
      w_ok_q  <= w_ok_d;
      awa_q   <= awa_d;
      wd_q    <= wd_d;
      ws_q    <= ws_d;
      bv_q    <= bv_d;
      br_q    <= br_d;
      rv_q    <= rv_d;
      rd_q    <= rd_d;
      rr_q    <= rr_d;
    end
  end

  assign serial_out_pin = so_q;
  assign serial_out_oe  = oe_q;
  assign wdog_service   = wdog_q;
  assign limp_home_on   = limp_q;
  assign irq            = irq_q;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_ro_end;
    commit && is_ro;
  endsequence
  sequence s_wr_end;
    commit && !is_ro && !entry;
  endsequence
  sequence s_ro_hdr;
    fsm_q == SRF_SHIFT && !cs_idle && ro_hit && cnt_q == `SRF_HDR_BITS;
  endsequence

  out_release_a: assert property (cs_idle && fsm_q == SRF_IDLE |=> !serial_out_oe)
    else $error("serial output driven while deselected");
  ro_keeps_state_a: assert property (s_ro_end ##0 !wr_go
    |=> $stable(regs_q[`SRF_CS_CFG]) && $stable(mode_q) && $stable(last_q))
    else $error("read only command changed state");
  wdog_pulse_a: assert property (commit |=> wdog_service ##1 !wdog_service)
    else $error("watchdog service pulse missing");
  ro_same_a: assert property (s_ro_hdr |=> serial_out_pin == $past(regs_q[sel][0]))
    else $error("read only data not sent in same frame");
  next_frame_a: assert property (s_wr_end |=> resp_q.cfg_sel == $past(sel)
    && resp_q.mode_select_bits == $past(mode_q))
    else $error("response not deferred to next frame");
  first_sleep_a: assert property (entry && mode_q == SRF_SLEEP |=> resp_q.cfg_sel
    == `SRF_CS_WAKE && resp_q.mode_select_bits == SRF_SLEEP)
    else $error("wrong first response after sleep");
  restart_fail_a: assert property (entry && mode_q == SRF_RESTART && rfail_q
    |=> resp_q.cfg_sel == `SRF_CS_LH && resp_q.mode_select_bits == SRF_RESTART)
    else $error("wrong first response after failure restart");
  restart_req_a: assert property (entry && mode_q == SRF_RESTART && !rfail_q
    |=> resp_q.cfg_sel == `SRF_CS_CFG)
    else $error("wrong first response after requested restart");
  first_noclr_a: assert property (entry && !commit && !(wr_go && awa_q == `SRF_A_WAKE)
    |=> $stable(regs_q[`SRF_CS_WAKE]))
    else $error("first response cleared wake flags");
  ro_clear_a: assert property (s_ro_end ##0 sel == `SRF_CS_WAKE && !wr_go
    |=> regs_q[`SRF_CS_WAKE] == 10'h000)
    else $error("read only did not clear wake flags");
  lh_off_a: assert property (s_wr_end ##0 sel == `SRF_CS_LH && !rxf.data[0] && !wr_go
    |=> regs_q[`SRF_CS_LH][`SRF_LH_HI:`SRF_LH_LO] == 3'h0 && !limp_home_on)
    else $error("limp home cause not cleared");
  rm_clear_a: assert property (mode_wr && mode_d != mode_q && mode_q == SRF_SLEEP
    |=> (regs_q[`SRF_CS_LH] & `SRF_RM_MASK) == 10'h000)
    else $error("restart reason kept after sleep");
endmodule : srf_core

// ---- tb/srf_host_model.sv ----
// Host microcontroller model acting as SPI master
`timescale 1ns/1ns
module srf_host_model (
  input  wire logic serial_out_pin, // Device data
  input  wire logic serial_out_oe,  // Device drive enable
  output logic      link_sclk,      // SPI clock, still between frames
  output logic      chip_select_n,  // Frame select, active low
  output logic      serial_in_pin   // Host data
);
  logic last;
  logic so_line;
  // A released line has no pull: show the inverse of the last bit
  assign so_line = serial_out_oe ? serial_out_pin : ~last;
  initial
  begin
    link_sclk = 1'b0;
    chip_select_n = 1'b1;
    serial_in_pin = 1'b0;
    last = 1'b0;
  end
  // Mode code 7 in bits 2:0 asks for a read only answer
  task xfer(input logic [15:0] tx, input int n, output logic [15:0] rx);
    rx = 16'h0000;
    // Pins move by non-blocking assignment so the sampling edge sees the old level
    chip_select_n <= 1'b0;
    #320;
    for (int i = 0; i < n; i++)
    begin
      serial_in_pin <= tx[i];
      #160;
      link_sclk <= 1'b1;
      rx[i] = so_line;
      last = so_line;
      #160;
      link_sclk <= 1'b0;
    end
    #160;
    chip_select_n <= 1'b1;
    serial_in_pin <= 1'b0;
    // Gap covers commit latency and the minimum high time
    #400;
  endtask : xfer
endmodule : srf_host_model

// ---- tb/test_srf_core.sv ----
// Self-checking bench of the SPI response framing core
`timescale 1ns/1ns
`include "srf_cfg.svh"
module test_srf_core;
  import srf_pkg::*;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, v;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp;
  logic        link_sclk, chip_select_n, serial_in_pin, serial_out_pin;
  logic        serial_out_oe, wdog_service, limp_home_on, irq;
  logic [9:0]  wake_e, lh_e, dd, cfg_e, dexp;
  srf_frame_t  r;
  int          n_errors, num_checks, wd_n, w0;
  srf_mode_t   pm [5] = '{SRF_SLEEP, SRF_FAILSAFE, SRF_RESTART, SRF_RESTART, SRF_INIT};
  logic        fl [5] = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b0};
  logic [2:0]  ecfg;
  srf_core uut (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
    .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
    .rvalid, .rready, .link_sclk, .chip_select_n, .serial_in_pin, .serial_out_pin,
    .serial_out_oe, .wdog_service, .limp_home_on, .irq);
  srf_host_model host (.serial_out_pin, .serial_out_oe, .link_sclk, .chip_select_n,
    .serial_in_pin);
  initial
  begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end
  always @(posedge aclk) if (wdog_service === 1'b1) wd_n <= wd_n + 1;
  task chk(input logic [31:0] s, input logic [31:0] e, input string nm);
    num_checks++;
    if (s !== e)
    begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task close_out;
    if (n_errors == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : close_out
  // Register that the first Normal frame must carry, from the mode left behind
  function automatic logic [2:0] first_cfg(input srf_mode_t m, input logic f);
    if (m == SRF_SLEEP)
      return `SRF_CS_WAKE;
    else if (m == SRF_FAILSAFE || (m == SRF_RESTART && f))
      return `SRF_CS_LH;
    else
      return `SRF_CS_CFG;
  endfunction : first_cfg
  task axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever
    begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid === 1'b1)
      begin
        bready <= 1'b0;
        chk(bresp, e, "bresp");
        break;
      end
    end
  endtask : axw
  task axr(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m,
           input logic [1:0] er);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever
    begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid === 1'b1)
      begin
        rready <= 1'b0;
        chk(rdata & m, e & m, "rdata");
        chk(rresp, er, "rresp");
        break;
      end
    end
  endtask : axr
  task frm(input srf_mode_t m, input logic [2:0] c, input logic [9:0] d, input int n);
    logic [15:0] x;
    host.xfer({d, c, m}, n, x);
    r = x;
    chk(serial_out_oe, 1'b0, "oe idle");
  endtask : frm
  initial
  begin
    #2_000_000;
    n_errors++;
    close_out;
  end
  initial
  begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
    {awaddr, araddr, wdata, wake_e, lh_e} = '0;
    wstrb = 4'hf;
    void'($urandom(32'h945a320f));
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (4) @(posedge aclk);
    axr(`SRF_A_MODE, 32'h0000_0004, 32'hffff_ffff, `SRF_RESP_OK);
    axr(8'h18, 32'h0000_0000, 32'hffff_ffff, `SRF_RESP_ERR);
    axw(`SRF_A_STAT, 32'h0000_0000, `SRF_RESP_ERR);
    // Load the chip configuration register so its later readout is meaningful
    cfg_e = 10'($urandom);
    frm(SRF_NORMAL, `SRF_CS_CFG, cfg_e, 16);
    chk(r.mode_select_bits, SRF_INIT, "reset mode");
    chk(r.cfg_sel, `SRF_CS_CFG, "reset cfg");
    chk(r.data, `SRF_REG_RST, "reset data");
    // ----------------------------------------
    // First answer after each way into Normal
    // ----------------------------------------
    for (int i = 0; i < 5; i++)
    begin
      v = $urandom & 32'h0000_03ff;
      axw(`SRF_A_WAKE, v, `SRF_RESP_OK);
      wake_e |= v[9:0];
      v = $urandom & 32'h0000_0003;
      axw(`SRF_A_LH, v, `SRF_RESP_OK);
      lh_e |= v[9:0];
      axw(`SRF_A_MODE, {28'h000_0000, fl[i], pm[i]}, `SRF_RESP_OK);
      axw(`SRF_A_MODE, 32'h0000_0000, `SRF_RESP_OK);
      dd = 10'($urandom);
      ecfg = first_cfg(pm[i], fl[i]);
      dexp = (ecfg == `SRF_CS_WAKE) ? wake_e : (ecfg == `SRF_CS_LH) ? lh_e : cfg_e;
      frm(SRF_NORMAL, `SRF_CS_WAKE, dd, 16);
      chk(r.mode_select_bits, pm[i], "first mode");
      chk(r.cfg_sel, ecfg, "first cfg");
      chk(r.data, dexp, "first data");
      if (pm[i] == SRF_SLEEP || pm[i] == SRF_FAILSAFE) lh_e[1:0] = 2'h0;
      axr(`SRF_A_WAKE, wake_e, 32'h0000_03ff, `SRF_RESP_OK);
      axr(`SRF_A_LH, lh_e, 32'h0000_03ff, `SRF_RESP_OK);
      w0 = wd_n;
      frm(SRF_READ_ONLY, `SRF_CS_WAKE, ~dd, 16);
      chk(r.cfg_sel, `SRF_CS_WAKE, "next cfg");
      chk(r.mode_select_bits, SRF_NORMAL, "next mode");
      chk(r.data, wake_e, "ro data");
      chk(wd_n, w0 + 1, "wdog");
      wake_e = 10'h000;
      axr(`SRF_A_WAKE, 32'h0000_0000, 32'h0000_03ff, `SRF_RESP_OK);
      axr(`SRF_A_LAST, {dd, `SRF_CS_WAKE, SRF_NORMAL}, 32'h0000_ffff, `SRF_RESP_OK);
      axr(`SRF_A_MODE, 32'h0000_0000, 32'h0000_0007, `SRF_RESP_OK);
    end
    // ----------------------------------------
    // Limp-home flags, causes and interrupt
    // ----------------------------------------
    axw(`SRF_A_LH, 32'h0000_0003, `SRF_RESP_OK);
    lh_e |= 10'h003;
    frm(SRF_READ_ONLY, `SRF_CS_LH, 10'h000, 16);
    chk(r.data, lh_e, "lh ro");
    lh_e[1:0] = 2'h0;
    axr(`SRF_A_LH, lh_e, 32'h0000_03ff, `SRF_RESP_OK);
    axw(`SRF_A_LH, 32'h0000_0014, `SRF_RESP_OK);
    repeat (2) @(posedge aclk);
    chk(limp_home_on, 1'b1, "limp on");
    frm(SRF_NORMAL, `SRF_CS_LH, 10'h000, 16);
    chk(limp_home_on, 1'b0, "limp off");
    axr(`SRF_A_LH, 32'h0000_0000, 32'h0000_001c, `SRF_RESP_OK);
    axw(`SRF_A_MASK, 32'h0000_0000, `SRF_RESP_OK);
    axr(`SRF_A_STAT, 32'h0000_0000, 32'h0000_0000, `SRF_RESP_OK);
    w0 = wd_n;
    frm(SRF_NORMAL, `SRF_CS_WAKE, 10'h000, 12);
    chk(wd_n, w0, "short wdog");
    chk(irq, 1'b0, "irq masked");
    axw(`SRF_A_MASK, 32'h0000_0008, `SRF_RESP_OK);
    repeat (2) @(posedge aclk);
    chk(irq, 1'b1, "irq set");
    axr(`SRF_A_STAT, 32'h0000_0008, 32'hffff_ffff, `SRF_RESP_OK);
    repeat (2) @(posedge aclk);
    chk(irq, 1'b0, "irq clear");
    close_out;
  end
endmodule : test_srf_core
